// ==== core/discrete_pin_channel.sv ====
// What this block does
// - as input, keep present pin level plus fifteen earlier sampled levels
// - newest sample sits in bit 15, older ones lower, oldest in bit 0
// - host picks one update trigger; history shifts only on that trigger
// - rate mode samples whenever timebase reaches the programmed interval word
// - as output, pin level changes only on a host request
// - service code 01 drives high, 10 low, 11 initializes, 00 idle
// - priority 00 disables the channel; 01, 10, 11 enable it
// - interrupt enable 1 lets the request reach the host, 0 suppresses it
//
// The implementer's own choices: the APB slave port and the address map.
module discrete_pin_channel #(
	parameter int HW = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pin_channel_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n,
	// interrupt
	output logic irq
);
	localparam int DW = pin_channel_pkg::DATA_W;
	localparam int SW = pin_channel_pkg::STAT_W;

	history_if #(.HW(HW)) hs ();

	pin_sampler #(.HW(HW)) u_sampler (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pin_in(pin_in),
		.hs(hs)
	);

	logic [DW-1:0] setup_r;
	logic [DW-1:0] setup_nxt;
	logic [DW-1:0] interval_r;
	logic [DW-1:0] tbase_r;
	logic [DW-1:0] tbase_nxt;
	logic [SW-1:0] status_r;
	logic [SW-1:0] status_nxt;
	logic [SW-1:0] mask_r;
	logic drive_r;
	logic oe_n_r;
	logic pin_out_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic irq_r;

	// apb decode
	wire setup_ph = psel & penable & ~pready_r;
	wire done_ph = psel & penable & pready_r;
	wire wr = done_ph & pwrite;
	wire rd = done_ph & ~pwrite;
	wire hit_setup = paddr == pin_channel_pkg::OFF_SETUP;
	wire hit_hist = paddr == pin_channel_pkg::OFF_HISTORY;
	wire hit_intv = paddr == pin_channel_pkg::OFF_INTERVAL;
	wire hit_stat = paddr == pin_channel_pkg::OFF_STATUS;
	wire hit_mask = paddr == pin_channel_pkg::OFF_MASK;
	wire mapped = hit_setup | hit_hist | hit_intv | hit_stat | hit_mask;

	wire [DW-1:0] rd_mux = hit_setup ? setup_r :
		hit_hist ? DW'(hs.history) :
		hit_intv ? interval_r :
		hit_stat ? DW'(status_r) :
		hit_mask ? DW'(mask_r) : '0;

	// channel fields
	wire [1:0] pri_f = pin_channel_pkg::field2(setup_r, pin_channel_pkg::PRI_LSB);
	wire [1:0] seq_f = pin_channel_pkg::field2(setup_r, pin_channel_pkg::SEQ_LSB);
	wire [1:0] svc_f = pin_channel_pkg::field2(setup_r, pin_channel_pkg::SVC_LSB);
	wire enabled = pri_f != pin_channel_pkg::PRI_OFF;

	// a pending request waits while the channel is disabled
	wire svc_go = enabled & (svc_f != pin_channel_pkg::SVC_NONE);
	wire svc_high = svc_go & (svc_f == pin_channel_pkg::SVC_HIGH);
	wire svc_low = svc_go & (svc_f == pin_channel_pkg::SVC_LOW);
	wire svc_init = svc_go & (svc_f == pin_channel_pkg::SVC_INIT);

	// history triggers, at most one chosen by seq_f; code 11 selects none
	wire as_input = enabled & ~drive_r;
	wire rate_mode = as_input & (seq_f == pin_channel_pkg::SEQ_RATE);
	wire rate_hit = rate_mode & (tbase_r == interval_r);
	wire edge_trig = as_input & (seq_f == pin_channel_pkg::SEQ_EDGE) & hs.rise_fall;
	wire host_trig = svc_init & (seq_f == pin_channel_pkg::SEQ_HOST);
	assign hs.shift_en = edge_trig | rate_hit | host_trig;

	assign tbase_nxt = !rate_mode ? '0 : rate_hit ? '0 : tbase_r + 1'b1;

	// service clears its own request field; a bus write in the same cycle wins
	wire [DW-1:0] svc_clr = ~(DW'(2'h3) << pin_channel_pkg::SVC_LSB);
	assign setup_nxt = (wr & hit_setup) ? (pwdata[DW-1:0] & pin_channel_pkg::SETUP_WMASK) :
		svc_go ? (setup_r & svc_clr) : setup_r;

	// read clears only the bits that were returned; write of 0 clears a bit
	wire [SW-1:0] st_set = {hs.shift_en, svc_go};
	wire [SW-1:0] st_rdclr = (rd & hit_stat) ? prdata_r[SW-1:0] : '0;
	wire [SW-1:0] st_wrclr = (wr & hit_stat) ? ~pwdata[SW-1:0] : '0;
	assign status_nxt = (status_r & ~(st_rdclr | st_wrclr)) | st_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else if (ce) begin
			pready_r <= setup_ph;
			pslverr_r <= setup_ph & ~mapped;
			prdata_r <= setup_ph & ~pwrite ? {{(32-DW){1'b0}}, rd_mux} : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_r <= pin_channel_pkg::SETUP_RST;
			interval_r <= pin_channel_pkg::INTERVAL_RST;
			mask_r <= pin_channel_pkg::STAT_RST;
			status_r <= pin_channel_pkg::STAT_RST;
			tbase_r <= '0;
		end else if (ce) begin
			setup_r <= setup_nxt;
			status_r <= status_nxt;
			tbase_r <= tbase_nxt;
			if (wr & hit_intv) begin
				interval_r <= pwdata[DW-1:0];
			end
			if (wr & hit_mask) begin
				mask_r <= pwdata[SW-1:0];
			end
		end
	end

	// pin direction and level move only on a serviced host request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_r <= 1'b0;
			oe_n_r <= 1'b1;
			pin_out_r <= 1'b0;
		end else if (ce) begin
			if (svc_high | svc_low) begin
				drive_r <= 1'b1;
				oe_n_r <= 1'b0;
				pin_out_r <= svc_high;
			end else if (svc_init) begin
				drive_r <= 1'b0;
				oe_n_r <= 1'b1;
			end
		end
	end

	// one cycle behind status, keeps the output a plain flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_r <= |(status_r & mask_r);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pin_out = pin_out_r;
	assign pin_oe_n = oe_n_r;
	assign irq = irq_r;

	sequence s_drive_req;
		svc_high | svc_low;
	endsequence

	sequence s_driving(logic lvl);
		drive_r && pin_out_r == lvl;
	endsequence

	property p_rate_sample;
		@(posedge pclk) disable iff (!presetn || !ce)
		rate_mode && tbase_r == interval_r |-> hs.shift_en ##1 tbase_r == '0;
	endproperty
	a_rate_sample: assert property (p_rate_sample) else $error("rate match missed");

	property p_pin_quiet;
		@(posedge pclk) disable iff (!presetn || !ce)
		!svc_go |=> $stable(pin_out_r) && $stable(drive_r);
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("pin moved on its own");

	property p_drive_level;
		@(posedge pclk) disable iff (!presetn || !ce)
		s_drive_req |=> s_driving($past(svc_high));
	endproperty
	a_drive_level: assert property (p_drive_level) else $error("wrong driven level");

	property p_init_release;
		@(posedge pclk) disable iff (!presetn || !ce)
		svc_init |=> !drive_r && svc_f == pin_channel_pkg::SVC_NONE;
	endproperty
	a_init_release: assert property (p_init_release) else $error("init did not release");

	property p_disabled;
		@(posedge pclk) disable iff (!presetn || !ce)
		pri_f == pin_channel_pkg::PRI_OFF |-> !svc_go && !hs.shift_en;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled channel active");

	property p_irq_gate;
		@(posedge pclk) disable iff (!presetn || !ce)
		##1 irq_r == $past(|(status_r & mask_r));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn || !ce)
		svc_go |=> status_r[pin_channel_pkg::ST_SERVICE];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("service flag not set");

	property p_hist_flag;
		@(posedge pclk) disable iff (!presetn || !ce)
		hs.shift_en |=> status_r[pin_channel_pkg::ST_HISTORY];
	endproperty
	a_hist_flag: assert property (p_hist_flag) else $error("history flag not set");

	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn || !ce)
		setup_ph |=> pready_r ##1 !pready_r;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");

	property p_read_zero;
		@(posedge pclk) disable iff (!presetn || !ce)
		setup_ph && pwrite |=> prdata_r == '0;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("write returned data");

	property p_slverr_map;
		@(posedge pclk) disable iff (!presetn || !ce)
		setup_ph |=> pslverr_r == !$past(mapped);
	endproperty
	a_slverr_map: assert property (p_slverr_map) else $error("error response wrong");

	property p_svc_clear;
		@(posedge pclk) disable iff (!presetn || !ce)
		svc_go && !(wr && hit_setup) |=> svc_f == pin_channel_pkg::SVC_NONE;
	endproperty
	a_svc_clear: assert property (p_svc_clear) else $error("request not cleared");

	property p_pending_wait;
		@(posedge pclk) disable iff (!presetn || !ce)
		!enabled && svc_f != pin_channel_pkg::SVC_NONE && !(wr && hit_setup) |=>
			svc_f == $past(svc_f) && $stable(drive_r);
	endproperty
	a_pending_wait: assert property (p_pending_wait) else $error("request lost");

	property p_no_shift_driving;
		@(posedge pclk) disable iff (!presetn || !ce)
		drive_r && !svc_init |-> !hs.shift_en;
	endproperty
	a_no_shift_driving: assert property (p_no_shift_driving) else $error("output sampled");

	property p_trigger_only;
		@(posedge pclk) disable iff (!presetn || !ce)
		hs.shift_en |-> (seq_f == pin_channel_pkg::SEQ_EDGE && hs.rise_fall) ||
			(seq_f == pin_channel_pkg::SEQ_RATE && tbase_r == interval_r) ||
			(seq_f == pin_channel_pkg::SEQ_HOST && svc_init);
	endproperty
	a_trigger_only: assert property (p_trigger_only) else $error("unselected trigger");

	property p_tbase_count;
		@(posedge pclk) disable iff (!presetn || !ce)
		rate_mode && tbase_r != interval_r |=> tbase_r == $past(tbase_r + 1'b1);
	endproperty
	a_tbase_count: assert property (p_tbase_count) else $error("timebase stalled");

	property p_wr_lands;
		@(posedge pclk) disable iff (!presetn || !ce)
		wr && hit_intv |=> interval_r == $past(pwdata[DW-1:0]);
	endproperty
	a_wr_lands: assert property (p_wr_lands) else $error("interval write lost");

	property p_irq_masked;
		@(posedge pclk) disable iff (!presetn || !ce)
		!(|(status_r & mask_r)) |=> !irq_r;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");

	property p_rd_clear;
		@(posedge pclk) disable iff (!presetn || !ce)
		rd && hit_stat |=> (status_r & $past(prdata_r[SW-1:0] & ~st_set)) == '0;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("status read kept bits");

	property p_set_wins;
		@(posedge pclk) disable iff (!presetn || !ce)
		|st_set |=> (status_r & $past(st_set)) == $past(st_set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("status set lost");

	property p_flag_hold;
		@(posedge pclk) disable iff (!presetn || !ce)
		status_r[pin_channel_pkg::ST_HISTORY] && !(rd && hit_stat) && !(wr && hit_stat) |=>
			status_r[pin_channel_pkg::ST_HISTORY];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("history flag dropped");
endmodule

// ==== core/pin_channel_pkg.sv ====
package pin_channel_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 12;
	localparam int STAT_W = 2;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_SETUP = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_HISTORY = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_INTERVAL = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_MASK = 12'h010;

	// channel_setup_word field positions
	localparam int PRI_LSB = 0;
	localparam int SEQ_LSB = 2;
	localparam int SVC_LSB = 4;
	localparam logic [DATA_W-1:0] SETUP_WMASK = 16'h003F;

	// priority codes
	localparam logic [1:0] PRI_OFF = 2'h0;

	// history update trigger codes
	localparam logic [1:0] SEQ_EDGE = 2'h0;
	localparam logic [1:0] SEQ_RATE = 2'h1;
	localparam logic [1:0] SEQ_HOST = 2'h2;

	// host_service_request codes
	localparam logic [1:0] SVC_NONE = 2'h0;
	localparam logic [1:0] SVC_HIGH = 2'h1;
	localparam logic [1:0] SVC_LOW = 2'h2;
	localparam logic [1:0] SVC_INIT = 2'h3;

	// status and mask bit positions
	localparam int ST_SERVICE = 0;
	localparam int ST_HISTORY = 1;

	// reset values
	localparam logic [DATA_W-1:0] SETUP_RST = 16'h0000;
	localparam logic [DATA_W-1:0] INTERVAL_RST = 16'h0000;
	localparam logic [DATA_W-1:0] HISTORY_RST = 16'h0000;
	localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

	function automatic logic [1:0] field2(input logic [DATA_W-1:0] w, input int lsb);
		field2 = w[lsb +: 2];
	endfunction
endpackage

// ==== core/history_if.sv ====
interface history_if #(parameter int HW = 16);
	logic shift_en;
	logic level;
	logic rise_fall;
	logic [HW-1:0] history;

	modport ctrl (output shift_en, input level, input rise_fall, input history);
	modport smp (input shift_en, output level, output rise_fall, output history);
endinterface

// ==== core/pin_sampler.sv ====
module pin_sampler #(
	parameter int HW = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// pin
	input wire logic pin_in,
	// controller side
	history_if.smp hs
);
	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	logic [HW-1:0] hist_r;
	logic [HW-1:0] hist_nxt;

	// newest level enters at the top, oldest falls off the bottom
	assign hist_nxt = hs.shift_en ? {sync2_r, hist_r[HW-1:1]} : hist_r;
	assign hs.level = sync2_r;
	assign hs.rise_fall = sync2_r ^ prev_r;
	assign hs.history = hist_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
			hist_r <= '0;
		end else if (ce) begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
			hist_r <= hist_nxt;
		end
	end

	property p_hist_shift;
		@(posedge pclk) disable iff (!presetn || !ce)
		hs.shift_en |=> hist_r[HW-1] == $past(sync2_r) && hist_r[HW-2:0] == $past(hist_r[HW-1:1]);
	endproperty
	a_hist_shift: assert property (p_hist_shift) else $error("history shift wrong");

	property p_hist_hold;
		@(posedge pclk) disable iff (!presetn || !ce)
		!hs.shift_en |=> $stable(hist_r);
	endproperty
	a_hist_hold: assert property (p_hist_hold) else $error("history moved without trigger");
endmodule

// ==== verification/pin_source.sv ====
module pin_source (
	// far-side level and the channel's drive
	input wire logic level,
	input wire logic pin_out,
	input wire logic pin_oe_n,
	// resolved wire seen by the channel
	output logic pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// the channel wins the wire while it drives; otherwise the outside source shows
	assign pin_in = pin_oe_n ? level : pin_out;
endmodule

// ==== verification/discrete_pin_channel_tb.sv ====
module discrete_pin_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic level = 1'b0;
	logic ce = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic pready, pslverr, perr, pin_in, pin_out, pin_oe_n, irq;
	int errors = 0;
	int check_count = 0;
	always #5 pclk = ~pclk;

	discrete_pin_channel u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .irq(irq));
	pin_source u_src (.level(level), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one setup cycle, then access held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			errors++;
			final_report();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask

	// lets the service result and the one-cycle interrupt lag land
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	logic [11:0] offs [5] = '{pin_channel_pkg::OFF_SETUP, pin_channel_pkg::OFF_HISTORY,
		pin_channel_pkg::OFF_INTERVAL, pin_channel_pkg::OFF_STATUS, pin_channel_pkg::OFF_MASK};

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (offs[i]) rd(offs[i], 32'h0);
		rd(12'h020, 32'h0);
		check(perr, 1'b1);
		check(pin_oe_n, 1'b1);
		wr(pin_channel_pkg::OFF_MASK, 32'h1);
		// a request under priority 00 must wait
		wr(pin_channel_pkg::OFF_SETUP, 32'h0010);
		settle(3);
		check(pin_oe_n, 1'b1);
		rd(pin_channel_pkg::OFF_SETUP, 32'h0010);
		wr(pin_channel_pkg::OFF_SETUP, 32'h0011);
		settle(3);
		check(pin_out, 1'b1);
		check(pin_oe_n, 1'b0);
		check(irq, 1'b1);
		rd(pin_channel_pkg::OFF_SETUP, 32'h0001);
		rd(pin_channel_pkg::OFF_STATUS, 32'h1);
		settle(3);
		check(irq, 1'b0);
		level <= 1'b1;
		settle(10);
		check(pin_out, 1'b1);
		wr(pin_channel_pkg::OFF_MASK, 32'h0);
		wr(pin_channel_pkg::OFF_SETUP, 32'h0021);
		settle(3);
		check(pin_out, 1'b0);
		check(irq, 1'b0);
		rd(pin_channel_pkg::OFF_STATUS, 32'h1);
		// host-request trigger: each initialize shifts one sample
		wr(pin_channel_pkg::OFF_SETUP, 32'h0039);
		settle(3);
		check(pin_oe_n, 1'b1);
		settle(8);
		wr(pin_channel_pkg::OFF_SETUP, 32'h0039);
		settle(3);
		rd(pin_channel_pkg::OFF_HISTORY, 32'h8000);
		rd(pin_channel_pkg::OFF_STATUS, 32'h3);
		level <= 1'b0;
		settle(10);
		rd(pin_channel_pkg::OFF_HISTORY, 32'h8000);
		wr(pin_channel_pkg::OFF_SETUP, 32'h0039);
		settle(3);
		rd(pin_channel_pkg::OFF_HISTORY, 32'h4000);
		// transition trigger
		wr(pin_channel_pkg::OFF_SETUP, 32'h0001);
		level <= 1'b1;
		settle(10);
		rd(pin_channel_pkg::OFF_HISTORY, 32'hA000);
		level <= 1'b0;
		settle(10);
		rd(pin_channel_pkg::OFF_HISTORY, 32'h5000);
		// rate trigger, period 8: exactly eight matches fall before the trigger is turned off
		wr(pin_channel_pkg::OFF_STATUS, 32'h0);
		wr(pin_channel_pkg::OFF_MASK, 32'h2);
		wr(pin_channel_pkg::OFF_INTERVAL, 32'h7);
		rd(pin_channel_pkg::OFF_INTERVAL, 32'h7);
		wr(pin_channel_pkg::OFF_SETUP, 32'h0005);
		level <= 1'b1;
		settle(64);
		wr(pin_channel_pkg::OFF_SETUP, 32'h000D);
		settle(3);
		check(irq, 1'b1);
		apb(1'b0, pin_channel_pkg::OFF_HISTORY, 32'h0);
		check(rdat, 32'h0000FF50);
		wr(pin_channel_pkg::OFF_STATUS, 32'h0);
		settle(3);
		check(irq, 1'b0);
		// a pin pulse while the clock enable is low must leave no trace
		wr(pin_channel_pkg::OFF_SETUP, 32'h0001);
		ce <= 1'b0;
		level <= 1'b0;
		settle(10);
		level <= 1'b1;
		settle(10);
		ce <= 1'b1;
		settle(10);
		rd(pin_channel_pkg::OFF_HISTORY, 32'h0000FF50);
		final_report();
	end
endmodule
